/* src/clock_control_pkg.sv */
// Package: register map, field positions, reset values and mode codes of the clock block
package clock_control_pkg;
    localparam logic [4:0] clock_reset_control_offset  = 5'h00;
    localparam logic [4:0] fast_clock_prescaler_offset = 5'h04;
    localparam logic [4:0] slow_clock_prescaler_offset = 5'h08;
    localparam logic [4:0] aux_clock_prescaler_offset  = 5'h0c;
    localparam logic [4:0] clock_status_offset         = 5'h10;

    // Control register field positions
    localparam int slow_source_select_bit  = 0;
    localparam int fast_source_select_bit  = 1;
    localparam int pll_power_down_bit      = 2;
    localparam int aux_clock1_enable_bit   = 3;
    localparam int aux_clock2_enable_bit   = 4;
    localparam int power_on_flag_bit       = 5;

    // Prescaler field positions
    localparam int fast_clock_divisor_lsb  = 0;
    localparam int pll_multiplier_lsb      = 4;
    localparam int aux_clock1_divisor_lsb  = 0;
    localparam int aux_clock2_divisor_lsb  = 4;

    // Values after reset
    localparam logic       slow_source_select_reset = 1'b0;
    localparam logic       fast_source_select_reset = 1'b1;
    localparam logic       pll_power_down_reset     = 1'b1;
    localparam logic       aux_enable_reset         = 1'b0;
    localparam logic       power_on_flag_reset      = 1'b1;
    localparam logic [7:0] fast_clock_prescaler_reset = 8'h4f;
    localparam logic [7:0] slow_clock_prescaler_reset = 8'hb6;
    localparam logic [7:0] aux_clock_prescaler_reset  = 8'hff;

    // PLL multiplier codes; all others reserved
    localparam logic [2:0] pll_times3 = 3'h3;
    localparam logic [2:0] pll_times4 = 3'h4;
    localparam logic [2:0] pll_times5 = 3'h5;

    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef enum logic [1:0] {
        mode_active = 2'b00,
        mode_save   = 2'b01,
        mode_idle   = 2'b10,
        mode_halt   = 2'b11
    } power_mode_t;
endpackage

/* src/clock_select_prescale_power_modes.sv */
// Clock source selection, prescalers and power-mode clock gating with an AXI4-Lite slave

module clk_divider #(
    parameter int W = 4
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         src_level,
    input  wire logic         run,
    input  wire logic [W-1:0] divisor,
    output logic              clk_out
);
    logic         src_prev;
    logic [W-1:0] cnt;
    logic [W:0]   half;
    logic         src_edge;

    assign src_edge = src_level & ~src_prev;
    // Extra bit keeps an all-ones divisor from wrapping the period to zero
    assign half     = ({1'b0, divisor} + (W+1)'(1)) >> 1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= src_level;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt <= '0;
        end else if (src_edge) begin
            cnt <= (cnt >= divisor) ? '0 : cnt + 1'b1;
        end
    end

    // Divide by divisor+1 counted on source rising edges; high for the first half
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            clk_out <= 1'b0;
        end else if (divisor == '0) begin
            clk_out <= src_level;
        end else begin
            clk_out <= ({1'b0, cnt} < half);
        end
    end
endmodule

module clock_select_prescale_power_modes
    import clock_control_pkg::*;
#(
    parameter logic [7:0] programming_mode_fast_clock_prescaler_reset = 8'h0f
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite slave
    input  wire logic [4:0]                    awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire logic [4:0]                    araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // Clock sources, sampled as levels
    input  wire logic                          main_clk,
    input  wire logic                          lf_osc_clk,
    input  wire logic                          pll_clk,
    input  wire logic                          main_osc_stable,
    input  wire logic                          pll_locked,
    input  wire logic                          power_up_detected,
    input  wire logic                          programming_mode,
    // From the power manager
    input  wire clock_control_pkg::power_mode_t mode_request,
    input  wire logic                          pll_disable_in_save,
    input  wire logic                          osc_disable_in_save,
    // Clock outputs and controls
    output logic                               sys_clk,
    output logic                               slow_clk,
    output logic                               aux_clk1,
    output logic                               aux_clk2,
    output logic                               pll_stop,
    output logic                               main_osc_enable,
    output logic [2:0]                         pll_multiplier,
    output clock_control_pkg::power_mode_t     power_mode
);
    import clock_control_pkg::*;

    logic        slow_source_select;
    logic        fast_source_select;
    logic        pll_power_down;
    logic        aux_clock1_enable;
    logic        aux_clock2_enable;
    logic        power_on_flag;
    logic [7:0]  fast_clock_prescaler;
    logic [7:0]  slow_clock_prescaler;
    logic [7:0]  aux_clock_prescaler;

    logic        aw_full;
    logic        w_full;
    logic [4:0]  aw_addr_q;
    logic [7:0]  w_byte_q;
    logic        w_lane0_q;
    logic        do_write;
    logic        next_aw_full;
    logic        next_w_full;
    logic        next_rvalid;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  rd_value;

    logic        mux_sel_pll;
    logic        presc_level;
    logic        main_running;
    logic        sys_div_out;
    logic        slow_div_out;
    logic        aux1_div_out;
    logic        aux2_div_out;
    logic        aux1_run;
    logic        aux2_run;
    logic        slow_run;

    // AXI4-Lite write path: address and data held separately, taken in either order
    assign do_write     = aw_full & w_full & ~bvalid;
    assign next_aw_full = (aw_full & ~do_write) | (awvalid & awready);
    assign next_w_full  = (w_full & ~do_write) | (wvalid & wready);
    assign next_rvalid  = (rvalid & ~rready) | (arvalid & arready);
    assign wr_hit       = (aw_addr_q == clock_reset_control_offset)
                        | (aw_addr_q == fast_clock_prescaler_offset)
                        | (aw_addr_q == slow_clock_prescaler_offset)
                        | (aw_addr_q == aux_clock_prescaler_offset);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_addr_q <= '0;
            w_byte_q  <= '0;
            w_lane0_q <= 1'b0;
        end else begin
            aw_full <= next_aw_full;
            w_full  <= next_w_full;
            awready <= ~next_aw_full;
            wready  <= ~next_w_full;
            if (awvalid && awready) begin
                aw_addr_q <= {awaddr[4:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_byte_q  <= wdata[7:0];
                w_lane0_q <= wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= resp_okay;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= (wr_hit || aw_addr_q == clock_status_offset) ? resp_okay : resp_slverr;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read path
    always_comb begin
        rd_hit   = 1'b1;
        rd_value = 8'h00;
        case ({araddr[4:2], 2'b00})
            clock_reset_control_offset: begin
                rd_value = {2'b00, power_on_flag, aux_clock2_enable, aux_clock1_enable,
                            pll_power_down, fast_source_select, slow_source_select};
            end
            fast_clock_prescaler_offset: rd_value = fast_clock_prescaler;
            slow_clock_prescaler_offset: rd_value = slow_clock_prescaler;
            aux_clock_prescaler_offset:  rd_value = aux_clock_prescaler;
            clock_status_offset: begin
                rd_value = {1'b0, main_running, pll_locked, main_osc_enable, pll_stop,
                            mux_sel_pll, power_mode};
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid  <= 1'b0;
            arready <= 1'b0;
            rdata   <= '0;
            rresp   <= resp_okay;
        end else begin
            rvalid  <= next_rvalid;
            arready <= ~next_rvalid;
            if (arvalid && arready) begin
                rdata <= {24'h000000, rd_value};
                rresp <= rd_hit ? resp_okay : resp_slverr;
            end
        end
    end

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_source_select <= slow_source_select_reset;
            fast_source_select <= fast_source_select_reset;
            pll_power_down     <= pll_power_down_reset;
            aux_clock1_enable  <= aux_enable_reset;
            aux_clock2_enable  <= aux_enable_reset;
        end else if (do_write && w_lane0_q && aw_addr_q == clock_reset_control_offset) begin
            slow_source_select <= w_byte_q[slow_source_select_bit];
            aux_clock1_enable  <= w_byte_q[aux_clock1_enable_bit];
            aux_clock2_enable  <= w_byte_q[aux_clock2_enable_bit];
            if (w_byte_q[fast_source_select_bit]) begin
                fast_source_select <= 1'b1;
            end else if (!pll_power_down && pll_locked) begin
                fast_source_select <= 1'b0;
            end
            if (!w_byte_q[pll_power_down_bit]) begin
                pll_power_down <= 1'b0;
            end else if (fast_source_select) begin
                pll_power_down <= 1'b1;
            end
        end
    end

    // Power-on flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_on_flag <= power_on_flag_reset;
        end else if (power_up_detected) begin
            power_on_flag <= 1'b1;
        end else if (do_write && w_lane0_q && aw_addr_q == clock_reset_control_offset
                     && !w_byte_q[power_on_flag_bit]) begin
            power_on_flag <= 1'b0;
        end
    end

    // Prescaler registers; reset value of the fast one depends on programming mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_clock_prescaler <= programming_mode ? programming_mode_fast_clock_prescaler_reset
                                                     : fast_clock_prescaler_reset;
            slow_clock_prescaler <= slow_clock_prescaler_reset;
            aux_clock_prescaler  <= aux_clock_prescaler_reset;
        end else if (do_write && w_lane0_q) begin
            if (aw_addr_q == fast_clock_prescaler_offset) begin
                fast_clock_prescaler <= {1'b0, w_byte_q[6:0]};
            end
            if (aw_addr_q == slow_clock_prescaler_offset) begin
                slow_clock_prescaler <= w_byte_q;
            end
            if (aw_addr_q == aux_clock_prescaler_offset) begin
                aux_clock_prescaler <= w_byte_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_multiplier <= fast_clock_prescaler_reset[pll_multiplier_lsb +: 3];
        end else begin
            pll_multiplier <= fast_clock_prescaler[pll_multiplier_lsb +: 3];
        end
    end

    // Power mode: idle and halt accepted only from active with both disables set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_mode <= mode_active;
        end else begin
            case (mode_request)
                mode_active: power_mode <= mode_active;
                mode_save: begin
                    if (power_mode == mode_active) begin
                        power_mode <= mode_save;
                    end
                end
                mode_idle, mode_halt: begin
                    if (power_mode == mode_active && pll_disable_in_save
                        && osc_disable_in_save) begin
                        power_mode <= mode_request;
                    end
                end
                default: power_mode <= power_mode;
            endcase
        end
    end

    // Oscillator and PLL enables per mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_osc_enable <= 1'b1;
            pll_stop        <= 1'b1;
        end else begin
            case (power_mode)
                mode_active: main_osc_enable <= 1'b1;
                mode_save:   main_osc_enable <= ~(osc_disable_in_save & slow_source_select);
                default:     main_osc_enable <= 1'b0;
            endcase
            pll_stop <= pll_power_down | (power_mode == mode_idle) | (power_mode == mode_halt)
                      | ((power_mode == mode_save) & pll_disable_in_save);
        end
    end

    assign main_running = main_osc_enable & main_osc_stable;

    // Glitch-free source switch: change only while both source levels are low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mux_sel_pll <= 1'b0;
        end else if (!main_clk && !pll_clk) begin
            mux_sel_pll <= ~fast_source_select;
        end
    end

    assign presc_level = mux_sel_pll ? (pll_clk & ~pll_stop) : (main_clk & main_running);
    assign aux1_run    = aux_clock1_enable & main_running;
    assign aux2_run    = aux_clock2_enable & main_running;
    assign slow_run    = (power_mode != mode_halt) & main_running;

    clk_divider #(.W(4)) sys_divider (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .src_level (presc_level),
        .run       (power_mode == mode_active),
        .divisor   (fast_clock_prescaler[fast_clock_divisor_lsb +: 4]),
        .clk_out   (sys_div_out)
    );

    clk_divider #(.W(9)) slow_divider (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .src_level (main_clk),
        .run       (slow_run),
        .divisor   ({slow_clock_prescaler, 1'b1}),
        .clk_out   (slow_div_out)
    );

    clk_divider #(.W(4)) aux1_divider (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .src_level (main_clk),
        .run       (aux1_run),
        .divisor   (aux_clock_prescaler[aux_clock1_divisor_lsb +: 4]),
        .clk_out   (aux1_div_out)
    );

    clk_divider #(.W(4)) aux2_divider (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .src_level (main_clk),
        .run       (aux2_run),
        .divisor   (aux_clock_prescaler[aux_clock2_divisor_lsb +: 4]),
        .clk_out   (aux2_div_out)
    );

    // Clock outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_clk <= 1'b0;
            aux_clk1 <= 1'b0;
            aux_clk2 <= 1'b0;
            sys_clk  <= 1'b0;
        end else begin
            if (power_mode == mode_halt) begin
                slow_clk <= 1'b0;
            end else begin
                slow_clk <= slow_source_select ? lf_osc_clk : slow_div_out;
            end
            aux_clk1 <= aux1_div_out;
            aux_clk2 <= aux2_div_out;
            case (power_mode)
                mode_active: sys_clk <= sys_div_out;
                mode_save:   sys_clk <= slow_source_select ? lf_osc_clk : slow_div_out;
                default:     sys_clk <= 1'b0;
            endcase
        end
    end
endmodule

/* bench/clock_ctrl_sva.sv */
// Checker: clock, oscillator and power-mode relations seen at the top ports
module clock_ctrl_sva
    import clock_control_pkg::*;
(
    input wire logic                           aclk,
    input wire logic                           aresetn,
    input wire logic                           bvalid,
    input wire logic                           main_osc_stable,
    input wire logic                           pll_disable_in_save,
    input wire logic                           osc_disable_in_save,
    input wire logic                           sys_clk,
    input wire logic                           slow_clk,
    input wire logic                           aux_clk1,
    input wire logic                           aux_clk2,
    input wire logic                           pll_stop,
    input wire logic                           main_osc_enable,
    input wire logic [2:0]                     pll_multiplier,
    input wire clock_control_pkg::power_mode_t power_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    import clock_control_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RESET_OUT: assert property ($rose(aresetn) |-> pll_stop && main_osc_enable
        && power_mode == mode_active && pll_multiplier == pll_times4)
        else $error("outputs wrong after reset");
    AST_MULT_WRITE: assert property ($changed(pll_multiplier) |-> $past(bvalid)
        || $past(bvalid, 2))
        else $error("multiplier changed without a write");
    AST_AUX1_STOP: assert property (!main_osc_stable [*3] |-> !aux_clk1)
        else $error("aux clock 1 runs without stable main clock");
    AST_AUX2_STOP: assert property (!main_osc_stable [*3] |-> !aux_clk2)
        else $error("aux clock 2 runs without stable main clock");
    AST_HALT_SLOW: assert property ((power_mode == mode_halt) [*3] |-> !slow_clk)
        else $error("slow clock active in halt");
    AST_NO_SYS: assert property ((power_mode inside {mode_idle, mode_halt}) [*3] |-> !sys_clk)
        else $error("system clock active in idle or halt");
    AST_HALT_OFF: assert property ((power_mode == mode_halt) [*3] |-> pll_stop
        && !main_osc_enable)
        else $error("oscillator or PLL on in halt");
    AST_ACTIVE_OSC: assert property ((power_mode == mode_active) [*3] |-> main_osc_enable)
        else $error("main oscillator off in active");
    AST_IDLE_ENTRY: assert property (power_mode == mode_idle && $past(power_mode) != mode_idle
        |-> $past(power_mode) == mode_active
        && ($past(pll_disable_in_save) || $past(pll_disable_in_save, 2))
        && ($past(osc_disable_in_save) || $past(osc_disable_in_save, 2)))
        else $error("idle entered illegally");
    AST_HALT_ENTRY: assert property (power_mode == mode_halt && $past(power_mode) != mode_halt
        |-> $past(power_mode) == mode_active
        && ($past(pll_disable_in_save) || $past(pll_disable_in_save, 2))
        && ($past(osc_disable_in_save) || $past(osc_disable_in_save, 2)))
        else $error("halt entered illegally");
endmodule

/* bench/tb_top.sv */
// Testbench: register accesses, clock edge counts and power-mode sequencing
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import clock_control_pkg::*;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [4:0]  awaddr = 5'h00;
    logic [4:0]  araddr = 5'h00;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        main_clk = 1'b0;
    logic        lf_osc_clk = 1'b0;
    logic        pll_clk = 1'b0;
    logic        main_osc_stable = 1'b1;
    logic        pll_locked = 1'b0;
    logic        power_up_detected = 1'b0;
    logic        programming_mode = 1'b0;
    power_mode_t mode_request = mode_active;
    logic        pll_disable_in_save = 1'b0;
    logic        osc_disable_in_save = 1'b0;
    logic        sys_clk, slow_clk, aux_clk1, aux_clk2, pll_stop, main_osc_enable;
    logic [2:0]  pll_multiplier;
    power_mode_t power_mode;
    logic [5:0]  src_cnt = 6'h00;
    logic [31:0] ecnt [4];
    logic [2:0]  codes [4] = '{3'h7, 3'h3, 3'h5, 3'h4};
    int          err_count = 0;
    int          checks_done = 0;
    int          tick = 0;

    // Programming-mode reset value chosen here; multiplier field left at 100
    clock_select_prescale_power_modes #(.programming_mode_fast_clock_prescaler_reset(8'h45)) DUT (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .main_clk, .lf_osc_clk, .pll_clk, .main_osc_stable, .pll_locked,
        .power_up_detected, .programming_mode, .mode_request, .pll_disable_in_save,
        .osc_disable_in_save, .sys_clk, .slow_clk, .aux_clk1, .aux_clk2, .pll_stop,
        .main_osc_enable, .pll_multiplier, .power_mode
    );

    always #2 aclk = ~aclk;

    // Main period 8, PLL period 4, low-frequency period 64 cycles
    always @(posedge aclk) begin
        src_cnt <= src_cnt + 6'h01;
        main_clk <= src_cnt[2];
        pll_clk <= src_cnt[1];
        lf_osc_clk <= src_cnt[5];
    end

    always @(posedge aclk) begin
        tick <= tick + 1;
        if (tick == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk(rdata, {24'h0, e});
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Rising edges of aux1, aux2, slow and system clock over 128 cycles
    task automatic edges();
        logic [3:0] p;
        logic [3:0] c;
        repeat (32) @(posedge aclk);
        p = {sys_clk, slow_clk, aux_clk2, aux_clk1};
        foreach (ecnt[i])
            ecnt[i] = 32'h0;
        repeat (128) begin
            @(posedge aclk);
            c = {sys_clk, slow_clk, aux_clk2, aux_clk1};
            foreach (ecnt[i])
                ecnt[i] += {31'h0, c[i] & ~p[i]};
            p = c;
        end
    endtask

    task automatic go(input power_mode_t m, input power_mode_t e);
        mode_request <= m;
        repeat (4) @(posedge aclk);
        chk({30'h0, power_mode}, {30'h0, e});
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(5'h00, 8'h26, resp_okay);
        rd_chk(5'h04, 8'h4f, resp_okay);
        rd_chk(5'h08, 8'hb6, resp_okay);
        rd_chk(5'h0c, 8'hff, resp_okay);
        rd_chk(5'h10, 8'h58, resp_okay);
        rd_chk(5'h14, 8'h00, resp_slverr);
        wr(5'h14, 8'h55, resp_slverr);
        wr(5'h00, 8'h26, resp_okay);
        rd_chk(5'h00, 8'h26, resp_okay);
        wr(5'h00, 8'h06, resp_okay);
        rd_chk(5'h00, 8'h06, resp_okay);
        power_up_detected <= 1'b1;
        @(posedge aclk);
        power_up_detected <= 1'b0;
        rd_chk(5'h00, 8'h26, resp_okay);
        wr(5'h00, 8'h04, resp_okay);
        rd_chk(5'h00, 8'h06, resp_okay);
        foreach (codes[i]) begin
            wr(5'h04, {1'b0, codes[i], 4'h1}, resp_okay);
            rd_chk(5'h04, {1'b0, codes[i], 4'h1}, resp_okay);
            chk({29'h0, pll_multiplier}, {29'h0, codes[i]});
        end
        wr(5'h00, 8'h02, resp_okay);
        rd_chk(5'h00, 8'h02, resp_okay);
        wr(5'h00, 8'h00, resp_okay);
        rd_chk(5'h00, 8'h02, resp_okay);
        pll_locked <= 1'b1;
        wr(5'h00, 8'h00, resp_okay);
        rd_chk(5'h00, 8'h00, resp_okay);
        chk({31'h0, pll_stop}, 32'h0);
        wr(5'h00, 8'h04, resp_okay);
        rd_chk(5'h00, 8'h00, resp_okay);
        rd_chk(5'h10, 8'h74, resp_okay);
        wr(5'h00, 8'h06, resp_okay);
        rd_chk(5'h00, 8'h02, resp_okay);
        wr(5'h00, 8'h06, resp_okay);
        rd_chk(5'h00, 8'h06, resp_okay);
        chk({31'h0, pll_stop}, 32'h1);
        wr(5'h0c, 8'h10, resp_okay);
        wr(5'h08, 8'h01, resp_okay);
        wr(5'h00, 8'h1e, resp_okay);
        edges();
        chk(ecnt[0], 32'h10);
        chk(ecnt[1], 32'h08);
        chk(ecnt[2], 32'h04);
        chk(ecnt[3], 32'h08);
        main_osc_stable <= 1'b0;
        edges();
        chk(ecnt[0], 32'h0);
        chk(ecnt[1], 32'h0);
        main_osc_stable <= 1'b1;
        wr(5'h00, 8'h1f, resp_okay);
        edges();
        chk(ecnt[2], 32'h02);
        go(mode_save, mode_save);
        edges();
        chk(ecnt[3], 32'h02);
        chk(ecnt[0], 32'h10);
        pll_disable_in_save <= 1'b1;
        osc_disable_in_save <= 1'b1;
        go(mode_idle, mode_save);
        chk({31'h0, main_osc_enable}, 32'h0);
        go(mode_active, mode_active);
        pll_disable_in_save <= 1'b0;
        osc_disable_in_save <= 1'b0;
        go(mode_idle, mode_active);
        pll_disable_in_save <= 1'b1;
        osc_disable_in_save <= 1'b1;
        go(mode_idle, mode_idle);
        edges();
        chk(ecnt[3], 32'h0);
        chk(ecnt[2], 32'h02);
        go(mode_active, mode_active);
        go(mode_halt, mode_halt);
        edges();
        chk(ecnt[2], 32'h0);
        chk(ecnt[3], 32'h0);
        chk({31'h0, main_osc_enable}, 32'h0);
        go(mode_active, mode_active);
        chk({31'h0, main_osc_enable}, 32'h1);
        // Second reset, started in programming mode
        aresetn <= 1'b0;
        programming_mode <= 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        programming_mode <= 1'b0;
        rd_chk(5'h04, 8'h45, resp_okay);
        rd_chk(5'h00, 8'h26, resp_okay);
        rd_chk(5'h10, 8'h78, resp_okay);
        tally_and_finish();
    end
endmodule

bind clock_select_prescale_power_modes clock_ctrl_sva sva_i (
    .aclk, .aresetn, .bvalid, .main_osc_stable, .pll_disable_in_save, .osc_disable_in_save,
    .sys_clk, .slow_clk, .aux_clk1, .aux_clk2, .pll_stop, .main_osc_enable, .pll_multiplier,
    .power_mode
);
